// ===== design/lhc_defs.vh
// limp-home configuration register constants: offsets, fields, resets, timing
// assumes a 50 MHz system clock and a 16-bit serial frame
`ifndef LHC_DEFS_VH
`define LHC_DEFS_VH

// ----------------------------------------
// register offsets and reset values
// ----------------------------------------
`define LHC_ADDR_CHAN_CFG 7'h1E
`define LHC_ADDR_FAULT_CFG 7'h1F
`define LHC_CHAN_CFG_RST 8'h00
`define LHC_FAULT_CFG_RST 8'h00

// ----------------------------------------
// channel config fields (per channel i the base is 3*i)
// ----------------------------------------
`define LHC_BIT_PHASE 7
`define LHC_BIT_EXT_REF 6
`define LHC_OFS_EN 0
`define LHC_OFS_INT_DIM 1
`define LHC_OFS_FORCE 2

// ----------------------------------------
// fault config fields (per channel i the base is 3*i)
// ----------------------------------------
`define LHC_TIMER_SEL_HI 7
`define LHC_TIMER_SEL_LO 6
`define LHC_OFS_LS_POL 0
`define LHC_OFS_HS_POL 1
`define LHC_OFS_TH_POL 2

// ----------------------------------------
// timing
// ----------------------------------------
`define LHC_CLK_MHZ 50
`define LHC_OC_BASE_US 3600
`define LHC_FRAME_BITS 16

`endif

// ===== design/lhc_limp_home_regs.v
// limp-home configuration registers of a dual-channel led driver, reached over spi,
// plus the fallback dimming, setpoint and fault-response logic they steer.
// assumes spi pins are asynchronous to clk_sys and are oversampled; fault and
// dim pins come from the analog side, also asynchronous.
//
// Behaviour
// - phase bit 0 gives half-period offset, 1 gives aligned internal dim waveforms.
// - ext-ref bit picks converter value else per-channel fallback setpoint registers.
// - channel 2 force bit drives full duty in fallback mode.
// - channel 2 dim source: external input or internal generator with width.
// - channel 2 enable bit turns channel 2 on or off in fallback.
// - channel 1 force bit drives full duty in fallback mode.
// - channel 1 dim source: external input or internal generator with width.
// - channel 1 enable bit turns channel 1 on or off in fallback.
// - channel config register at 0x1E, reset 0x00, all bits read/write.
// - fault config at 0x1F, reset 0, timer select and per-channel policies.
// - every fault config field is read/write and steers fault handling.
// - timer select gives 3.6, 7.2, 14.4 or 28.8 ms retry hold.
// - policy 0 auto-restarts; policy 1 clears enable until host re-sets it.
// - led and latch-off configuration acts only in fallback mode; the ext-ref bit steers the setpoints in every mode.
`timescale 1ns/1ps
`include "lhc_defs.vh"

module lhc_limp_home_regs #(
  parameter DIM_BITS = 10,
  parameter OC_BASE_CYCLES = `LHC_OC_BASE_US * `LHC_CLK_MHZ
) (
  input wire clk_sys,
  input wire nrst,
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_mosi,
  output wire spi_miso_o,
  output wire spi_miso_oe,
  input wire fallback_mode,
  input wire [1:0] ext_dim_in,
  input wire [1:0] thermal_fault,
  input wire [1:0] highside_oc_fault,
  input wire [1:0] lowside_oc_fault,
  input wire [DIM_BITS-1:0] dim_generator_divider,
  input wire [DIM_BITS-1:0] ch1_fallback_dim_width,
  input wire [DIM_BITS-1:0] ch2_fallback_dim_width,
  input wire [DIM_BITS-1:0] ch1_fallback_current_setpoint,
  input wire [DIM_BITS-1:0] ch2_fallback_current_setpoint,
  input wire [DIM_BITS-1:0] external_reference_code,
  output reg [1:0] ch_led_on_q,
  output reg [DIM_BITS-1:0] ch1_active_current_setpoint_q,
  output reg [DIM_BITS-1:0] ch2_active_current_setpoint_q,
  output wire [7:0] chan_cfg_out,
  output wire [7:0] fault_cfg_out
);

  localparam TW = 22;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  reg [10:0] sync1_q;
  reg [10:0] sync2_q;
  wire [10:0] async_in = {spi_sclk, spi_cs_n, spi_mosi, ext_dim_in, thermal_fault,
                          highside_oc_fault, lowside_oc_fault};

  // two flops per pin; only the second stage feeds logic
  // reset to the idle levels (sclk low, select high) so no false edge follows reset
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 11'h200;
      sync2_q <= 11'h200;
    end else begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
    end
  end

  wire sclk_s = sync2_q[10];
  wire cs_n_s = sync2_q[9];
  wire mosi_s = sync2_q[8];
  wire [1:0] dim_s = sync2_q[7:6];
  wire [1:0] th_s = sync2_q[5:4];
  wire [1:0] hs_s = sync2_q[3:2];
  wire [1:0] ls_s = sync2_q[1:0];

  // ----------------------------------------
  // spi slave, mode 0, frame {wr, addr[6:0], data[7:0]}
  // ----------------------------------------
  reg sclk_prev_q;
  reg [4:0] bit_cnt_q;
  reg [15:0] rx_q;
  reg [7:0] tx_q;
  reg miso_q;
  reg [7:0] chan_cfg_q;
  reg [7:0] fault_cfg_q;
  wire sclk_rise = sclk_s & ~sclk_prev_q;
  wire sclk_fall = ~sclk_s & sclk_prev_q;
  wire [15:0] rx_next = {rx_q[14:0], mosi_s};
  wire wr_done = ~cs_n_s & sclk_rise && (bit_cnt_q == 5'd15) && rx_q[14];
  wire [6:0] wr_addr = rx_q[13:7];

  // unmapped addresses read as zero
  function [7:0] rd_mux;
    input [6:0] addr;
    begin
      if (addr == `LHC_ADDR_CHAN_CFG)
        rd_mux = chan_cfg_q;
      else if (addr == `LHC_ADDR_FAULT_CFG)
        rd_mux = fault_cfg_q;
      else
        rd_mux = 8'h00;
    end
  endfunction

  // shift in on rising sclk, shift out on falling; a frame restarts on cs high
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sclk_prev_q <= 1'b0;
      bit_cnt_q <= 5'd0;
      rx_q <= 16'h0000;
      tx_q <= 8'h00;
      miso_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      if (cs_n_s) begin
        bit_cnt_q <= 5'd0;
        miso_q <= 1'b0;
      end else begin
        if (sclk_rise) begin
          rx_q <= rx_next;
          bit_cnt_q <= bit_cnt_q + 5'd1;
          // read data is latched once the address byte is complete
          if (bit_cnt_q == 5'd7)
            tx_q <= rd_mux(rx_next[6:0]);
        end
        if (sclk_fall && bit_cnt_q >= 5'd8 && bit_cnt_q < 5'd16) begin
          miso_q <= tx_q[7];
          tx_q <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  assign spi_miso_o = miso_q;
  assign spi_miso_oe = ~cs_n_s;

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  wire [7:0] en_clear;

  // channel and fault config write
  // host write beats a same-cycle latch-off so a re-enable is never lost
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      chan_cfg_q <= `LHC_CHAN_CFG_RST;
      fault_cfg_q <= `LHC_FAULT_CFG_RST;
    end else begin
      if (wr_done && wr_addr == `LHC_ADDR_CHAN_CFG)
        chan_cfg_q <= rx_next[7:0];
      else
        chan_cfg_q <= chan_cfg_q & ~en_clear;
      if (wr_done && wr_addr == `LHC_ADDR_FAULT_CFG)
        fault_cfg_q <= rx_next[7:0];
    end
  end

  assign chan_cfg_out = chan_cfg_q;
  assign fault_cfg_out = fault_cfg_q;

  // ----------------------------------------
  // internal dimming generator
  // ----------------------------------------
  reg [DIM_BITS-1:0] pre_cnt_q;
  reg [DIM_BITS-1:0] period_cnt_q;
  wire gen_tick = (pre_cnt_q >= dim_generator_divider);
  localparam [DIM_BITS-1:0] HALF = {1'b1, {(DIM_BITS-1){1'b0}}};

  // prescaler makes a one-cycle enable for the shared period counter
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pre_cnt_q <= {DIM_BITS{1'b0}};
      period_cnt_q <= {DIM_BITS{1'b0}};
    end else if (gen_tick) begin
      pre_cnt_q <= {DIM_BITS{1'b0}};
      period_cnt_q <= period_cnt_q + {{(DIM_BITS-1){1'b0}}, 1'b1};
    end else begin
      pre_cnt_q <= pre_cnt_q + {{(DIM_BITS-1){1'b0}}, 1'b1};
    end
  end

  wire [DIM_BITS-1:0] ch2_phase_cnt = chan_cfg_q[`LHC_BIT_PHASE] ? period_cnt_q
                                      : period_cnt_q - HALF;
  wire [1:0] gen_dim;
  assign gen_dim[0] = period_cnt_q < ch1_fallback_dim_width;
  assign gen_dim[1] = ch2_phase_cnt < ch2_fallback_dim_width;

  // ----------------------------------------
  // per-channel duty and fault response
  // ----------------------------------------
  wire [1:0] duty;
  wire [1:0] hold;
  wire [TW-1:0] oc_limit = OC_BASE_CYCLES[TW-1:0] << fault_cfg_q[7:6];

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_ch
      wire en = chan_cfg_q[3*i+`LHC_OFS_EN];
      wire pol_th = fault_cfg_q[3*i+`LHC_OFS_TH_POL];
      wire pol_hs = fault_cfg_q[3*i+`LHC_OFS_HS_POL];
      wire pol_ls = fault_cfg_q[3*i+`LHC_OFS_LS_POL];
      wire act = fallback_mode & en;
      reg [TW-1:0] oc_timer_q;

      // full duty; override wins over both sources
      assign duty[i] = chan_cfg_q[3*i+`LHC_OFS_FORCE] ? 1'b1
                       : chan_cfg_q[3*i+`LHC_OFS_INT_DIM] ? gen_dim[i] : dim_s[i];

      assign en_clear[3*i+2:3*i] = {2'b00, act & ((th_s[i] & pol_th) | (hs_s[i] & pol_hs)
                                                  | (ls_s[i] & pol_ls))};

      // auto-restart after hold; a repeat fault restarts the wait
      always @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
          oc_timer_q <= {TW{1'b0}};
        else if (act & ((hs_s[i] & ~pol_hs) | (ls_s[i] & ~pol_ls)))
          oc_timer_q <= oc_limit;
        else if (oc_timer_q != {TW{1'b0}})
          oc_timer_q <= oc_timer_q - {{(TW-1){1'b0}}, 1'b1};
      end

      // thermal auto-restart follows the analog hysteresis level
      assign hold[i] = (oc_timer_q != {TW{1'b0}}) | (th_s[i] & ~pol_th);
    end
  endgenerate
  assign en_clear[7:6] = 2'b00;

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // leds in fallback only; setpoints follow ext-ref in every mode
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ch_led_on_q <= 2'b00;
      ch1_active_current_setpoint_q <= {DIM_BITS{1'b0}};
      ch2_active_current_setpoint_q <= {DIM_BITS{1'b0}};
    end else begin
      ch_led_on_q <= {2{fallback_mode}} & {chan_cfg_q[3], chan_cfg_q[0]} & ~hold & duty;
      if (chan_cfg_q[`LHC_BIT_EXT_REF]) begin
        ch1_active_current_setpoint_q <= external_reference_code;
        ch2_active_current_setpoint_q <= external_reference_code;
      end else begin
        ch1_active_current_setpoint_q <= ch1_fallback_current_setpoint;
        ch2_active_current_setpoint_q <= ch2_fallback_current_setpoint;
      end
    end
  end

endmodule

// ===== tb/lhc_limp_home_regs_bench.sv
// self-checking bench for the limp-home registers
// assumes design/lhc_defs.vh on the include path
`timescale 1ns/1ps
`include "lhc_defs.vh"
module lhc_limp_home_regs_bench;
  localparam OC = 40;
  reg clk_sys, nrst, fb;
  reg [1:0] dim, tf, hs, ls;
  reg [9:0] dv, w1, w2, sp1, sp2, ec;
  reg [7:0] rd;
  wire sclk, cs_n, mosi, miso, oe;
  wire [1:0] led;
  wire [9:0] a1, a2;
  wire [7:0] cfg, flt;
  integer error_cnt, cmp_count, seed, i, m_ch, m_flt, ad, n1, n2, nb;
  int cfgs[8] = '{8'h05, 8'h01, 8'h03, 8'h28, 8'h18, 8'h08, 8'hAD, 8'h36};
  lhc_spi_host host (.spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso_o(miso));
  lhc_limp_home_regs #(.OC_BASE_CYCLES(OC)) DUT (.clk_sys(clk_sys), .nrst(nrst),
    .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso_o(miso), .spi_miso_oe(oe),
    .fallback_mode(fb), .ext_dim_in(dim), .thermal_fault(tf), .highside_oc_fault(hs),
    .lowside_oc_fault(ls), .dim_generator_divider(dv), .ch1_fallback_dim_width(w1),
    .ch2_fallback_dim_width(w2), .ch1_fallback_current_setpoint(sp1),
    .ch2_fallback_current_setpoint(sp2), .external_reference_code(ec), .ch_led_on_q(led),
    .ch1_active_current_setpoint_q(a1), .ch2_active_current_setpoint_q(a2),
    .chan_cfg_out(cfg), .fault_cfg_out(flt));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[ERR] %0s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // model keeps the two registers, unmapped writes drop
  task wr(input [6:0] a, input [7:0] d);
    @(posedge clk_sys);
    #1 host.xfer({1'b1, a, d}, rd);
    if (a == `LHC_ADDR_CHAN_CFG) m_ch = d;
    if (a == `LHC_ADDR_FAULT_CFG) m_flt = d;
  endtask
  task wt(input integer n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // zero widths: internal generator never on
  function [1:0] led_m(input integer c, input integer d);
    integer k;
    for (k = 0; k < 2; k++)
      led_m[k] = c[3*k] & (c[3*k+2] | (!c[3*k+1] & d[k]));
  endfunction
  // cycles per 1024-tick period where both channels are on; ph 0 delays ch2 by half
  function integer ovl(input integer a, input integer b, input integer ph);
    integer k;
    ovl = 0;
    for (k = 0; k < 1024; k++)
      ovl += ((k < a) && (((k + (ph ? 0 : 512)) % 1024) < b));
  endfunction
  task results;
    if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #1_000_000 error_cnt = error_cnt + 1;
    results;
  end
  initial begin
    seed = 32'ha6fa;
    {error_cnt, cmp_count, m_ch, m_flt, nrst, fb, dim, tf, hs, ls, w1, w2} = 0;
    {dv, sp1, sp2, ec} = {$random(seed), $random(seed)};
    wt(6);
    nrst = 1'b1;
    chk("cfg_rst", cfg, 8'h00);
    chk("flt_rst", flt, 8'h00);
    wt(4);
    // random access, 0x20 and 0x21 unmapped
    for (i = 0; i < 8; i++) begin
      ad = 30 + ($random(seed) & 3);
      wr(ad, $random(seed));
      host.xfer({1'b0, 7'(ad), 8'h00}, rd);
      chk("read", rd, ad == 30 ? m_ch : ad == 31 ? m_flt : 0);
      chk("cfg", cfg, m_ch);
      chk("flt", flt, m_flt);
    end
    wr(7'h1F, 8'h00);
    fb = 1'b1;
    for (i = 0; i < 8; i++) begin
      dim = $random(seed);
      wr(7'h1E, cfgs[i]);
      wt(4);
      chk("led", led, led_m(m_ch, dim));
    end
    for (i = 0; i < 2; i++) begin
      wr(7'h1E, 8'h09 | (i << 6));
      wt(3);
      chk("sp1", a1, i ? ec : sp1);
      chk("sp2", a2, i ? ec : sp2);
    end
    // internal generator at one tick per clock: on-time per period and channel overlap
    dv = 10'h000;
    w1 = 10'd700;
    w2 = 10'd600;
    for (i = 0; i < 2; i++) begin
      wr(7'h1E, 8'h1B | (i << 7));
      wt(2);
      {n1, n2, nb} = 0;
      repeat (1024) begin
        wt(1);
        n1 += led[0];
        n2 += led[1];
        nb += led[0] & led[1];
      end
      chk("gen_on1", n1, w1);
      chk("gen_on2", n2, w2);
      chk("gen_both", nb, ovl(w1, w2, i));
    end
    fb = 1'b0;
    wt(3);
    chk("led_nofb", led, 2'b00);
    fb = 1'b1;
    // ch1 thermal and ch2 low-side latch policies, both channels forced on
    wr(7'h1F, 8'h0C);
    wr(7'h1E, 8'h2D);
    tf = 2'b01;
    ls = 2'b10;
    wt(6);
    chk("latch_cfg", cfg, 8'h24);
    chk("latch_led", led, 2'b00);
    tf = 2'b00;
    ls = 2'b00;
    wr(7'h1E, 8'h2D);
    wt(4);
    chk("reenable", led, 2'b11);
    // selector 01 doubles the base hold
    wr(7'h1F, 8'h40);
    hs = 2'b01;
    wt(3);
    hs = 2'b00;
    wt(OC * 3 / 2);
    chk("oc_hold", led, 2'b10);
    wt(OC);
    chk("oc_retry", led, 2'b11);
    results;
  end
endmodule

// ===== tb/lhc_properties.sv
// checker for the limp-home register block ports
// assumes clk_sys domain only, nrst async low
`timescale 1ns/1ps
module lhc_props #(parameter DIM_BITS = 10) (
  input wire clk_sys,
  input wire nrst,
  input wire spi_cs_n,
  input wire spi_miso_oe,
  input wire fallback_mode,
  input wire [1:0] thermal_fault,
  input wire [DIM_BITS-1:0] ch1_fallback_current_setpoint,
  input wire [DIM_BITS-1:0] external_reference_code,
  input wire [DIM_BITS-1:0] ch1_active_current_setpoint_q,
  input wire [1:0] ch_led_on_q,
  input wire [7:0] chan_cfg_out,
  input wire [7:0] fault_cfg_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // reset holds both registers clear
  AST_RST_VAL: assert property (disable iff (1'b0) !nrst |-> !chan_cfg_out && !fault_cfg_out)
    else $error("config not clear in reset");
  AST_NO_FALLBACK: assert property (!fallback_mode |=> ch_led_on_q == 2'b00)
    else $error("led on outside fallback");
  AST_CH1_OFF: assert property (!chan_cfg_out[0] |=> !ch_led_on_q[0])
    else $error("ch1 on while disabled");
  AST_CH2_OFF: assert property (!chan_cfg_out[3] |=> !ch_led_on_q[1])
    else $error("ch2 on while disabled");
  AST_SP_EXT: assert property (fallback_mode && chan_cfg_out[6]
    |=> ch1_active_current_setpoint_q == $past(external_reference_code)) else $error("ext setpoint");
  AST_SP_INT: assert property (fallback_mode && !chan_cfg_out[6]
    |=> ch1_active_current_setpoint_q == $past(ch1_fallback_current_setpoint)) else $error("setpoint");
  // oe follows the synchronised select, so it needs a few cycles
  AST_OE_IDLE: assert property (spi_cs_n [*3] |-> !spi_miso_oe)
    else $error("miso driven while idle");
  AST_LATCH: assert property ((fallback_mode && chan_cfg_out[0] && fault_cfg_out[2]
    && thermal_fault[0]) [*3] |-> ##[0:2] !chan_cfg_out[0]) else $error("no latch-off");
  COV_ON: cover property (ch_led_on_q == 2'b11);
  COV_EXT: cover property (fallback_mode && chan_cfg_out[6]);
  COV_LATCH: cover property (fault_cfg_out[2] && $fell(chan_cfg_out[0]));
endmodule
bind lhc_limp_home_regs lhc_props #(.DIM_BITS(DIM_BITS)) u_props (.clk_sys(clk_sys),
  .nrst(nrst), .spi_cs_n(spi_cs_n), .spi_miso_oe(spi_miso_oe), .fallback_mode(fallback_mode),
  .thermal_fault(thermal_fault), .ch1_fallback_current_setpoint(ch1_fallback_current_setpoint),
  .external_reference_code(external_reference_code), .ch_led_on_q(ch_led_on_q),
  .ch1_active_current_setpoint_q(ch1_active_current_setpoint_q),
  .chan_cfg_out(chan_cfg_out), .fault_cfg_out(fault_cfg_out));

// ===== tb/lhc_spi_host.sv
// spi host model, mode 0, 160 ns sclk, msb first 16-bit frames
// assumes callers enter xfer just after a clk_sys edge
`timescale 1ns/1ps
module lhc_spi_host (
  output reg spi_sclk,
  output reg spi_cs_n,
  output reg spi_mosi,
  input wire spi_miso_o
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  task xfer(input [15:0] frm, output [7:0] rd);
    integer i;
    begin
      spi_cs_n = 1'b0;
      for (i = 15; i >= 0; i = i - 1) begin
        spi_mosi = frm[i];
        #80 spi_sclk = 1'b1;
        // sample late in the high phase, miso lags the falling edge
        #80 if (i < 8) rd[i] = spi_miso_o;
        spi_sclk = 1'b0;
      end
      #80 spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi; // released line shows no stale value
      #160;
    end
  endtask
endmodule
